// ---- dtc_pin_model.sv ----
// model of the external count pins and gate pins of both timers
`timescale 1ns/100ps

module dtc_pin_model (
	input wire logic clk_in, // system clock
	output logic pin_zero_out, // count pin, timer 0
	output logic pin_one_out, // count pin, timer 1
	output logic gate_zero_out, // gate pin, timer 0
	output logic gate_one_out // gate pin, timer 1
);
	initial begin
		pin_zero_out = 1'b1;
		pin_one_out = 1'b1;
		gate_zero_out = 1'b0;
		gate_one_out = 1'b0;
	end

	// =========================================
	// slow falling edges, long enough to sync
	task automatic pulse(input int which, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_in);
			if (which == 0) pin_zero_out <= 1'b0;
			else pin_one_out <= 1'b0;
			repeat (3) @(posedge clk_in);
			if (which == 0) pin_zero_out <= 1'b1;
			else pin_one_out <= 1'b1;
			repeat (3) @(posedge clk_in);
		end
	endtask

	task automatic set_gate(input int which, input logic lvl);
		@(posedge clk_in);
		if (which == 0) gate_zero_out <= lvl;
		else gate_one_out <= lvl;
	endtask
endmodule // dtc_pin_model

// ---- dtc_pkg.sv ----
// package: register map, field positions and modes of the dual timer/counter
package dtc_pkg;
	// register indices on the plain register port
	localparam logic [2:0] ADDR_MODE = 3'h0;
	localparam logic [2:0] ADDR_CTRL = 3'h1;
	localparam logic [2:0] ADDR_T0_LOW = 3'h2;
	localparam logic [2:0] ADDR_T0_HIGH = 3'h3;
	localparam logic [2:0] ADDR_T1_LOW = 3'h4;
	localparam logic [2:0] ADDR_T1_HIGH = 3'h5;
	localparam logic [2:0] ADDR_IRQ_MASK = 3'h6;
	// timer_mode_config fields
	localparam int MODE_GATE1_BIT = 7;
	localparam int MODE_SRC1_BIT = 6;
	localparam int MODE_FIELD1_LSB = 4;
	localparam int MODE_GATE0_BIT = 3;
	localparam int MODE_SRC0_BIT = 2;
	localparam int MODE_FIELD0_LSB = 0;
	// timer_control_reg fields
	localparam int CTRL_OVF1_BIT = 7;
	localparam int CTRL_RUN1_BIT = 6;
	localparam int CTRL_OVF0_BIT = 5;
	localparam int CTRL_RUN0_BIT = 4;
	// mode field codes
	localparam logic [1:0] MODE_PRESCALE13 = 2'h0;
	localparam logic [1:0] MODE_CASCADE16 = 2'h1;
	localparam logic [1:0] MODE_RELOAD8 = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [4:0] PRESCALE_MAX = 5'h1f;
	localparam logic [7:0] BYTE_MAX = 8'hff;
	localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
endpackage : dtc_pkg

// ---- dtc_timer.sv ----
// file: dual timer/counter with mode, control, count and mask registers
`timescale 1ns/100ps

// Operation
// - mode 0: thirteen bits, high byte plus five
// - rollover to zero sets overflow flag
// - count only when run and gate allow, except split high byte: run bit one alone
// - setting run keeps count contents
// - gate select bits at mode bits 7, 3
// - bit 2 picks clock or count pin zero
// - bits 1..0 select timer zero mode
// - mode 1: sixteen-bit cascade, no prescaler
// - mode 2: low overflows reload from high
// - split: high byte uses timer one controls
// - timer one in mode 3 holds
// - overflow flag cleared by service or software
// - run bits changed only by software
// - bit 6 picks clock or count pin one
module dtc_timer (
	input wire logic sys_clk_in, // system clock, 50 MHz
	input wire logic rst_n_in, // synchronous reset, active low
	input wire logic [2:0] reg_addr_in, // register index
	input wire logic [7:0] reg_wdata_in, // write data
	input wire logic reg_wr_in, // write strobe
	input wire logic reg_rd_in, // read strobe
	input wire logic count_pin_zero_in, // external count pin, timer 0
	input wire logic count_pin_one_in, // external count pin, timer 1
	input wire logic external_gate_input_zero_in, // gate pin, timer 0
	input wire logic external_gate_input_one_in, // gate pin, timer 1
	input wire logic service_ack_zero_in, // interrupt serviced pulse, flag 0
	input wire logic service_ack_one_in, // interrupt serviced pulse, flag 1
	output logic [7:0] reg_rdata_out, // read data, cycle after read strobe
	output logic irq_out // level interrupt, unmasked flag set
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [7:0] mode;
		logic run0;
		logic run1;
		logic ovf0;
		logic ovf1;
		logic [7:0] low0;
		logic [7:0] high0;
		logic [7:0] low1;
		logic [7:0] high1;
		logic [1:0] mask;
		logic [1:0] pin0_sync;
		logic [1:0] pin1_sync;
		logic pin0_prev;
		logic pin1_prev;
		logic [7:0] rdata;
		logic irq;
	} dtc_state_type;

	dtc_state_type st_q;
	dtc_state_type st_d;

	logic [1:0] mode0;
	logic [1:0] mode1;
	logic fall0;
	logic fall1;
	logic tick0;
	logic tick1;
	logic tick_split_high;
	logic en0;
	logic en1;
	logic [8:0] sum_low0;
	logic [8:0] sum_high0;
	logic [8:0] sum_low1;
	logic [8:0] sum_high1;
	logic ovf0_evt;
	logic ovf1_evt;
	logic wr_ctrl;
	logic [7:0] ctrl_view;

	assign mode0 = st_q.mode[dtc_pkg::MODE_FIELD0_LSB +: 2];
	assign mode1 = st_q.mode[dtc_pkg::MODE_FIELD1_LSB +: 2];
	// edge detectors read only the second synchroniser stage
	assign fall0 = st_q.pin0_prev & ~st_q.pin0_sync[1];
	assign fall1 = st_q.pin1_prev & ~st_q.pin1_sync[1];
	// gated count enables
	assign en0 = st_q.run0 & (~st_q.mode[dtc_pkg::MODE_GATE0_BIT]
		| external_gate_input_zero_in);
	assign en1 = st_q.run1 & (~st_q.mode[dtc_pkg::MODE_GATE1_BIT]
		| external_gate_input_one_in) & (mode1 != dtc_pkg::MODE_SPLIT);
	assign tick0 = en0 & (st_q.mode[dtc_pkg::MODE_SRC0_BIT] ? fall0 : 1'b1);
	assign tick1 = en1 & (st_q.mode[dtc_pkg::MODE_SRC1_BIT] ? fall1 : 1'b1);
	// split high byte: timer only, run by timer one run bit
	assign tick_split_high = (mode0 == dtc_pkg::MODE_SPLIT) & st_q.run1;
	assign sum_low0 = {1'b0, st_q.low0} + 9'h001;
	assign sum_high0 = {1'b0, st_q.high0} + 9'h001;
	assign sum_low1 = {1'b0, st_q.low1} + 9'h001;
	assign sum_high1 = {1'b0, st_q.high1} + 9'h001;
	assign wr_ctrl = reg_wr_in & (reg_addr_in == dtc_pkg::ADDR_CTRL);
	assign ctrl_view = {st_q.ovf1, st_q.run1, st_q.ovf0, st_q.run0, 4'h0};

	// ==========================================================
	// next state
	always_comb begin
		st_d = st_q;
		ovf0_evt = 1'b0;
		ovf1_evt = 1'b0;
		st_d.pin0_sync = {st_q.pin0_sync[0], count_pin_zero_in};
		st_d.pin1_sync = {st_q.pin1_sync[0], count_pin_one_in};
		st_d.pin0_prev = st_q.pin0_sync[1];
		st_d.pin1_prev = st_q.pin1_sync[1];

		// software writes first; counting below overrides count bytes on a tick
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				dtc_pkg::ADDR_MODE: st_d.mode = reg_wdata_in;
				dtc_pkg::ADDR_CTRL: begin
					// run bits only from software; counts untouched
					st_d.run1 = reg_wdata_in[dtc_pkg::CTRL_RUN1_BIT];
					st_d.run0 = reg_wdata_in[dtc_pkg::CTRL_RUN0_BIT];
					st_d.ovf1 = reg_wdata_in[dtc_pkg::CTRL_OVF1_BIT];
					st_d.ovf0 = reg_wdata_in[dtc_pkg::CTRL_OVF0_BIT];
				end
				dtc_pkg::ADDR_T0_LOW: st_d.low0 = reg_wdata_in;
				dtc_pkg::ADDR_T0_HIGH: st_d.high0 = reg_wdata_in;
				dtc_pkg::ADDR_T1_LOW: st_d.low1 = reg_wdata_in;
				dtc_pkg::ADDR_T1_HIGH: st_d.high1 = reg_wdata_in;
				dtc_pkg::ADDR_IRQ_MASK: st_d.mask = reg_wdata_in[1:0];
				default: ;
			endcase
		end
		if (service_ack_zero_in) begin
			st_d.ovf0 = 1'b0;
		end
		if (service_ack_one_in) begin
			st_d.ovf1 = 1'b0;
		end

		// timer 0
		if (tick0) begin
			unique case (mode0)
				dtc_pkg::MODE_PRESCALE13: begin
					// low five bits prescale; upper three left as they are
					st_d.low0[4:0] = sum_low0[4:0];
					if (st_q.low0[4:0] == dtc_pkg::PRESCALE_MAX) begin
						st_d.high0 = sum_high0[7:0];
						ovf0_evt = sum_high0[8];
					end
				end
				dtc_pkg::MODE_CASCADE16: begin
					st_d.low0 = sum_low0[7:0];
					if (sum_low0[8]) begin
						st_d.high0 = sum_high0[7:0];
						ovf0_evt = sum_high0[8];
					end
				end
				dtc_pkg::MODE_RELOAD8: begin
					st_d.low0 = sum_low0[8] ? st_q.high0 : sum_low0[7:0];
					ovf0_evt = sum_low0[8];
				end
				dtc_pkg::MODE_SPLIT: begin
					st_d.low0 = sum_low0[7:0];
					ovf0_evt = sum_low0[8];
				end
			endcase
		end
		if (tick_split_high) begin
			st_d.high0 = sum_high0[7:0];
			ovf1_evt = sum_high0[8];
		end

		// timer 1 (mode 3 already held off by its enable)
		if (tick1) begin
			unique case (mode1)
				dtc_pkg::MODE_PRESCALE13: begin
					st_d.low1[4:0] = sum_low1[4:0];
					if (st_q.low1[4:0] == dtc_pkg::PRESCALE_MAX) begin
						st_d.high1 = sum_high1[7:0];
						// flag belongs to split high byte while timer 0 is split
						ovf1_evt = ovf1_evt | (sum_high1[8] & ~tick_split_high);
					end
				end
				dtc_pkg::MODE_CASCADE16: begin
					st_d.low1 = sum_low1[7:0];
					if (sum_low1[8]) begin
						st_d.high1 = sum_high1[7:0];
						ovf1_evt = ovf1_evt | (sum_high1[8] & ~tick_split_high);
					end
				end
				dtc_pkg::MODE_RELOAD8: begin
					st_d.low1 = sum_low1[8] ? st_q.high1 : sum_low1[7:0];
					ovf1_evt = ovf1_evt | (sum_low1[8] & ~tick_split_high);
				end
				default: ;
			endcase
		end

		// set wins over any clear in the same cycle
		if (ovf0_evt) begin
			st_d.ovf0 = 1'b1;
		end
		if (ovf1_evt) begin
			st_d.ovf1 = 1'b1;
		end

		st_d.irq = |({st_d.ovf1, st_d.ovf0} & st_d.mask);
		st_d.rdata = 8'h00;
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				dtc_pkg::ADDR_MODE: st_d.rdata = st_q.mode;
				dtc_pkg::ADDR_CTRL: st_d.rdata = ctrl_view;
				dtc_pkg::ADDR_T0_LOW: st_d.rdata = st_q.low0;
				dtc_pkg::ADDR_T0_HIGH: st_d.rdata = st_q.high0;
				dtc_pkg::ADDR_T1_LOW: st_d.rdata = st_q.low1;
				dtc_pkg::ADDR_T1_HIGH: st_d.rdata = st_q.high1;
				dtc_pkg::ADDR_IRQ_MASK: st_d.rdata = {6'h00, st_q.mask};
				default: st_d.rdata = 8'h00;
			endcase
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata_out = st_q.rdata;
	assign irq_out = st_q.irq;

	// ==========================================================
	// checks
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_t0_rel_wrap;
		tick0 && mode0 == dtc_pkg::MODE_RELOAD8 && st_q.low0 == dtc_pkg::BYTE_MAX
			&& !tick_split_high && !reg_wr_in;
	endsequence

	AST_RELOAD_FROM_HIGH: assert property (s_t0_rel_wrap |=>
		st_q.low0 == $past(st_q.high0) && st_q.high0 == $past(st_q.high0))
		else $error("reload did not copy high byte");
	AST_RELOAD_SETS_FLAG: assert property (s_t0_rel_wrap |=> st_q.ovf0)
		else $error("overflow flag not set on reload");
	AST_GATE_BLOCKS: assert property ((!en0 && !reg_wr_in && mode0 != dtc_pkg::MODE_SPLIT)
		|=> $stable(st_q.low0) && $stable(st_q.high0))
		else $error("timer zero counted while gated off");
	AST_T1_MODE3_HOLDS: assert property ((mode1 == dtc_pkg::MODE_SPLIT && !reg_wr_in)
		|=> $stable(st_q.low1) && $stable(st_q.high1))
		else $error("timer one moved in mode 3");
	AST_RUN_KEEPS_COUNT: assert property ((wr_ctrl && !tick0 && !tick_split_high)
		|=> $stable(st_q.low0) && $stable(st_q.high0))
		else $error("control write altered count");
	AST_CASCADE_CARRY: assert property ((tick0 && mode0 == dtc_pkg::MODE_CASCADE16
		&& st_q.low0 == dtc_pkg::BYTE_MAX && !reg_wr_in)
		|=> st_q.low0 == 8'h00 && st_q.high0 == $past(st_q.high0) + 8'h01)
		else $error("sixteen-bit carry wrong");
	AST_PRESCALE_CARRY: assert property ((tick1 && mode1 == dtc_pkg::MODE_PRESCALE13
		&& st_q.low1[4:0] == dtc_pkg::PRESCALE_MAX && !reg_wr_in)
		|=> st_q.low1[4:0] == 5'h00 && st_q.high1 == $past(st_q.high1) + 8'h01)
		else $error("thirteen-bit carry wrong");
	AST_SERVICE_CLEARS: assert property ((service_ack_zero_in && !ovf0_evt
		&& !(wr_ctrl && reg_wdata_in[dtc_pkg::CTRL_OVF0_BIT])) |=> !st_q.ovf0)
		else $error("service did not clear flag");
	AST_EXT_EDGE_COUNT: assert property ((en0 && st_q.mode[dtc_pkg::MODE_SRC0_BIT]
		&& !fall0 && !reg_wr_in && mode0 == dtc_pkg::MODE_CASCADE16) |=> $stable(st_q.low0))
		else $error("counter moved without pin edge");
	AST_SPLIT_HIGH: assert property ((tick_split_high && st_q.high0 == dtc_pkg::BYTE_MAX)
		|=> st_q.ovf1)
		else $error("split high byte overflow lost");

	// ==========================================================
	// multi-step checks, six of them built from named sequences
	sequence s_t0_wrap13;
		tick0 && mode0 == dtc_pkg::MODE_PRESCALE13
			&& st_q.low0[4:0] == dtc_pkg::PRESCALE_MAX && st_q.high0 == dtc_pkg::BYTE_MAX;
	endsequence

	sequence s_t0_wrap16;
		tick0 && mode0 == dtc_pkg::MODE_CASCADE16
			&& st_q.low0 == dtc_pkg::BYTE_MAX && st_q.high0 == dtc_pkg::BYTE_MAX;
	endsequence

	sequence s_t1_wrap13;
		tick1 && mode1 == dtc_pkg::MODE_PRESCALE13 && !tick_split_high
			&& st_q.low1[4:0] == dtc_pkg::PRESCALE_MAX && st_q.high1 == dtc_pkg::BYTE_MAX;
	endsequence

	// pin high, then low for three samples: edge has crossed the synchroniser
	sequence s_pin0_fall;
		count_pin_zero_in ##1 !count_pin_zero_in [*3];
	endsequence

	sequence s_pin0_rise;
		!count_pin_zero_in ##1 count_pin_zero_in [*3];
	endsequence

	sequence s_pin1_fall;
		count_pin_one_in ##1 !count_pin_one_in [*3];
	endsequence

	AST_T0_WRAP13_FLAG: assert property (s_t0_wrap13 |=> st_q.ovf0)
		else $error("thirteen-bit rollover left flag clear");
	AST_T0_WRAP16_FLAG: assert property (s_t0_wrap16 |=> st_q.ovf0)
		else $error("sixteen-bit rollover left flag clear");
	AST_T1_WRAP13_FLAG: assert property (s_t1_wrap13 |=> st_q.ovf1)
		else $error("timer one rollover left flag clear");
	AST_T0_PRESCALE_CARRY: assert property ((tick0 && mode0 == dtc_pkg::MODE_PRESCALE13
		&& st_q.low0[4:0] == dtc_pkg::PRESCALE_MAX && !reg_wr_in)
		|=> st_q.low0[4:0] == 5'h00 && st_q.high0 == $past(st_q.high0) + 8'h01)
		else $error("timer zero thirteen-bit carry wrong");
	AST_PRESCALE_HIGH_WAITS: assert property ((tick0 && mode0 == dtc_pkg::MODE_PRESCALE13
		&& st_q.low0[4:0] != dtc_pkg::PRESCALE_MAX && !reg_wr_in) |=> $stable(st_q.high0))
		else $error("high byte moved inside prescale");
	AST_PRESCALE_TOP_KEPT: assert property ((tick0 && mode0 == dtc_pkg::MODE_PRESCALE13
		&& !reg_wr_in) |=> $stable(st_q.low0[7:5]))
		else $error("prescale upper bits changed");
	AST_INTERNAL_EVERY_CLOCK: assert property ((en0 && !st_q.mode[dtc_pkg::MODE_SRC0_BIT]
		&& mode0 == dtc_pkg::MODE_CASCADE16 && st_q.low0 != dtc_pkg::BYTE_MAX && !reg_wr_in)
		|=> st_q.low0 == $past(st_q.low0) + 8'h01 && $stable(st_q.high0))
		else $error("internal source missed a clock");
	AST_SPLIT_HIGH_COUNTS: assert property ((tick_split_high && !reg_wr_in)
		|=> st_q.high0 == $past(st_q.high0) + 8'h01)
		else $error("split high byte did not count");
	AST_SPLIT_LOW_OWN_RUN: assert property ((mode0 == dtc_pkg::MODE_SPLIT && !st_q.run0
		&& !reg_wr_in) |=> $stable(st_q.low0))
		else $error("split low byte ran without its run bit");
	AST_GATE1_BLOCKS: assert property ((st_q.mode[dtc_pkg::MODE_GATE1_BIT]
		&& !external_gate_input_one_in && !reg_wr_in)
		|=> $stable(st_q.low1) && $stable(st_q.high1))
		else $error("timer one counted while gated off");
	AST_RUN_SOFTWARE_ONLY: assert property (!wr_ctrl
		|=> $stable(st_q.run0) && $stable(st_q.run1))
		else $error("run bit changed without a control write");
	AST_CTRL_WRITE_KEEPS_T1: assert property ((wr_ctrl && !tick1)
		|=> $stable(st_q.low1) && $stable(st_q.high1))
		else $error("control write altered timer one count");
	AST_SW_CLEARS_FLAG: assert property ((wr_ctrl && !reg_wdata_in[dtc_pkg::CTRL_OVF0_BIT]
		&& !ovf0_evt) |=> !st_q.ovf0)
		else $error("software write did not clear flag");
	AST_SERVICE_CLEARS_ONE: assert property ((service_ack_one_in && !ovf1_evt
		&& !(wr_ctrl && reg_wdata_in[dtc_pkg::CTRL_OVF1_BIT])) |=> !st_q.ovf1)
		else $error("service did not clear flag one");
	AST_FLAG_STICKY: assert property ((st_q.ovf0 && !wr_ctrl && !service_ack_zero_in)
		|=> st_q.ovf0)
		else $error("flag zero dropped by itself");
	AST_PIN0_EDGE_SEEN: assert property (s_pin0_fall |-> fall0)
		else $error("falling pin edge not detected");
	AST_PIN0_RISE_IGNORED: assert property (s_pin0_rise |-> !fall0)
		else $error("rising pin edge counted");
	AST_PIN1_EDGE_COUNTS: assert property ((s_pin1_fall ##0 (en1
		&& st_q.mode[dtc_pkg::MODE_SRC1_BIT] && mode1 == dtc_pkg::MODE_CASCADE16
		&& st_q.low1 != dtc_pkg::BYTE_MAX && !reg_wr_in))
		|=> st_q.low1 == $past(st_q.low1) + 8'h01)
		else $error("timer one missed a pin edge");
	AST_PIN1_QUIET: assert property ((en1 && st_q.mode[dtc_pkg::MODE_SRC1_BIT] && !fall1
		&& mode1 == dtc_pkg::MODE_CASCADE16 && !reg_wr_in) |=> $stable(st_q.low1))
		else $error("timer one moved without pin edge");
endmodule // dtc_timer

// ---- dtc_timer_test.sv ----
// self-checking testbench of the dual timer/counter
`timescale 1ns/100ps

module dtc_timer_test;
	logic clk, rst_n, wr, rd, ack0, ack1, irq, p0, p1, g0, g1;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, v, p;
	logic [31:0] seed;
	int mismatches, n_compared, n;

	dtc_timer uut (.sys_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.count_pin_zero_in(p0), .count_pin_one_in(p1),
		.external_gate_input_zero_in(g0), .external_gate_input_one_in(g1),
		.service_ack_zero_in(ack0), .service_ack_one_in(ack1),
		.reg_rdata_out(rdata), .irq_out(irq));
	dtc_pin_model pm (.clk_in(clk), .pin_zero_out(p0), .pin_one_out(p1),
		.gate_zero_out(g0), .gate_one_out(g1));

	// =========================================
	// helpers
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [2:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic wait_flag(input int b, input int lim);
		for (int i = 0; i <= lim; i++) begin
			rd_reg(dtc_pkg::ADDR_CTRL);
			if (v[b] === 1'b1) return;
		end
		chk("flag wait", 8'h01, 8'h00);
		stop_test();
	endtask

	task automatic ack(input int which);
		@(posedge clk);
		if (which == 0) ack0 <= 1'b1;
		else ack1 <= 1'b1;
		@(posedge clk);
		ack0 <= 1'b0;
		ack1 <= 1'b0;
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// =========================================
	// main sequence
	initial begin
		{rst_n, wr, rd, ack0, ack1, addr, wdata} = '0;
		seed = 81;
		mismatches = 0;
		n_compared = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(dtc_pkg::ADDR_CTRL);
		chk("ctrl reset", 8'h00, v);
		wr_reg(3'h7, 8'hff);
		rd_reg(3'h7);
		chk("unmapped", 8'h00, v);
		$display("test reset done");
		p = rnd();
		wr_reg(dtc_pkg::ADDR_T0_LOW, p);
		wr_reg(dtc_pkg::ADDR_MODE, 8'h09);
		wr_reg(dtc_pkg::ADDR_CTRL, 8'h10);
		repeat (10) @(posedge clk);
		rd_reg(dtc_pkg::ADDR_T0_LOW);
		chk("gated low", p, v);
		pm.set_gate(0, 1'b1);
		repeat (6) @(posedge clk);
		wr_reg(dtc_pkg::ADDR_CTRL, 8'h00);
		rd_reg(dtc_pkg::ADDR_T0_LOW);
		chk("gate open", 8'h01, {7'h0, v !== p});
		pm.set_gate(0, 1'b0);
		$display("test gate done");
		wr_reg(dtc_pkg::ADDR_IRQ_MASK, 8'h01);
		wr_reg(dtc_pkg::ADDR_T0_LOW, 8'hfe);
		wr_reg(dtc_pkg::ADDR_T0_HIGH, 8'hff);
		wr_reg(dtc_pkg::ADDR_MODE, 8'h01);
		wr_reg(dtc_pkg::ADDR_CTRL, 8'h10);
		wait_flag(dtc_pkg::CTRL_OVF0_BIT, 10);
		chk("irq on", 8'h01, {7'h0, irq});
		wr_reg(dtc_pkg::ADDR_CTRL, 8'h00);
		rd_reg(dtc_pkg::ADDR_T0_HIGH);
		chk("cascade high", 8'h00, v);
		rd_reg(dtc_pkg::ADDR_CTRL);
		chk("sw clear", 8'h00, v);
		chk("irq off", 8'h00, {7'h0, irq});
		$display("test mode1 done");
		wr_reg(dtc_pkg::ADDR_T0_HIGH, 8'hff);
		wr_reg(dtc_pkg::ADDR_T0_LOW, 8'h1d);
		wr_reg(dtc_pkg::ADDR_MODE, 8'h00);
		wr_reg(dtc_pkg::ADDR_CTRL, 8'h10);
		wait_flag(dtc_pkg::CTRL_OVF0_BIT, 10);
		wr_reg(dtc_pkg::ADDR_CTRL, 8'h20);
		wr_reg(dtc_pkg::ADDR_IRQ_MASK, 8'h00);
		rd_reg(dtc_pkg::ADDR_CTRL);
		chk("masked irq", 8'h00, {7'h0, irq});
		ack(0);
		rd_reg(dtc_pkg::ADDR_CTRL);
		chk("service clear", 8'h00, v);
		$display("test mode0 done");
		wr_reg(dtc_pkg::ADDR_T0_HIGH, 8'h80);
		wr_reg(dtc_pkg::ADDR_T0_LOW, 8'hfc);
		wr_reg(dtc_pkg::ADDR_MODE, 8'h02);
		wr_reg(dtc_pkg::ADDR_CTRL, 8'h10);
		wait_flag(dtc_pkg::CTRL_OVF0_BIT, 10);
		wr_reg(dtc_pkg::ADDR_CTRL, 8'h00);
		rd_reg(dtc_pkg::ADDR_T0_HIGH);
		chk("reload high", 8'h80, v);
		rd_reg(dtc_pkg::ADDR_T0_LOW);
		chk("reloaded low", 8'h01, {7'h0, v[7]});
		$display("test mode2 done");
		p = rnd();
		wr_reg(dtc_pkg::ADDR_T0_LOW, p);
		wr_reg(dtc_pkg::ADDR_T0_HIGH, 8'hfa);
		wr_reg(dtc_pkg::ADDR_MODE, 8'h03);
		wr_reg(dtc_pkg::ADDR_CTRL, 8'h40);
		wait_flag(dtc_pkg::CTRL_OVF1_BIT, 10);
		rd_reg(dtc_pkg::ADDR_T0_LOW);
		chk("split low", p, v);
		wr_reg(dtc_pkg::ADDR_CTRL, 8'h00);
		wr_reg(dtc_pkg::ADDR_T1_LOW, p);
		wr_reg(dtc_pkg::ADDR_MODE, 8'h30);
		wr_reg(dtc_pkg::ADDR_CTRL, 8'h40);
		repeat (10) @(posedge clk);
		rd_reg(dtc_pkg::ADDR_T1_LOW);
		chk("t1 held", p, v);
		wr_reg(dtc_pkg::ADDR_CTRL, 8'h00);
		$display("test split done");
		wr_reg(dtc_pkg::ADDR_T1_LOW, 8'h1e);
		wr_reg(dtc_pkg::ADDR_T1_HIGH, 8'hff);
		wr_reg(dtc_pkg::ADDR_IRQ_MASK, 8'h02);
		wr_reg(dtc_pkg::ADDR_MODE, 8'h80);
		wr_reg(dtc_pkg::ADDR_CTRL, 8'h40);
		repeat (10) @(posedge clk);
		rd_reg(dtc_pkg::ADDR_T1_LOW);
		chk("t1 gated low", 8'h1e, v);
		pm.set_gate(1, 1'b1);
		wait_flag(dtc_pkg::CTRL_OVF1_BIT, 10);
		chk("irq one on", 8'h01, {7'h0, irq});
		ack(1);
		rd_reg(dtc_pkg::ADDR_CTRL);
		chk("service clear one", 8'h40, v);
		chk("irq one off", 8'h00, {7'h0, irq});
		wr_reg(dtc_pkg::ADDR_CTRL, 8'h00);
		pm.set_gate(1, 1'b0);
		rd_reg(dtc_pkg::ADDR_T1_HIGH);
		chk("t1 high wrapped", 8'h00, v);
		$display("test timer one done");
		for (int k = 0; k < 4; k++) begin
			p = rnd() & 8'h7f;
			n = int'(rnd() % 8'd15) + 1;
			wr_reg(k[0] ? dtc_pkg::ADDR_T1_LOW : dtc_pkg::ADDR_T0_LOW, p);
			wr_reg(dtc_pkg::ADDR_MODE, k[0] ? 8'h50 : 8'h05);
			wr_reg(dtc_pkg::ADDR_CTRL, k[0] ? 8'h40 : 8'h10);
			pm.pulse(k % 2, n);
			repeat (8) @(posedge clk);
			rd_reg(k[0] ? dtc_pkg::ADDR_T1_LOW : dtc_pkg::ADDR_T0_LOW);
			chk("pin count", p + n[7:0], v);
			wr_reg(dtc_pkg::ADDR_CTRL, 8'h00);
		end
		$display("test counter done");
		stop_test();
	end
endmodule // dtc_timer_test
